//--- timer_channel_action_control.sv
// Eight-channel timer control: pin actions, capture edges, counter, flags and requests
// Function
// - Overflow-toggle bit set makes the channel's compare pin invert on each counter overflow.
// - Overflow toggle acts only on output-compare channels; capture channels ignore it.
// - Overflow toggle beats forced compare; channel-7 override beats overflow toggle.
// - Mode/level pair on compare: 00 off, 01 toggle, 10 clear, 11 set.
// - Mode or level bit one makes the channel pin an output of its compare logic.
// - Edge select pair: 00 disabled, 01 rising, 10 falling, 11 any edge.
// - Channel interrupt requested only when flag and matching enable bit both set.
// - Overflow enable bit 7 of system_ctrl_two gates the overflow flag request.
// - Clear-on-7 bit 3 set: channel-7 compare resets the counter, modulus counting.
// - Clear-on-7 bit zero: counter never reset by compare, free runs 16 bits.
// - Clearing on with channel-7 value zero keeps the counter at zero.
// - Clearing on with channel-7 value maximum: compare reset sets no overflow flag.
// - Three-bit divider select divides bus clock by two to the field value.
// - Toggle and both action registers read and write at any time.
// - New divider value applies only when all prescaler stages are zero.
// - Overflow flag sets when the counter rolls from maximum to zero.
// - Channel-7 compare overrides simultaneous compare actions of the channels whose ch7_override_mask bit is set.
`timescale 1ns/10ps
`default_nettype none
module timer_channel_action_control (
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire timer_ctrl_pkg::bus_req_s bus,
    output logic [7:0]                    rd_data,
    input  wire logic [7:0][15:0]         compare_value,
    input  wire logic [7:0]               channel_io_select,
    input  wire logic [7:0]               ch7_override_mask,
    input  wire logic [7:0]               ch7_override_data,
    input  wire logic [7:0]               force_compare,
    input  wire logic [7:0]               pin_in,
    output timer_ctrl_pkg::pin_drive_s    pin_drive,
    output logic [7:0]                    capture_strobe,
    output logic [15:0]                   main_counter,
    output logic                          irq_channel,
    output logic                          irq_overflow
);
    logic [7:0]  overflow_toggle_enable;
    logic [7:0]  act_hi;
    logic [7:0]  act_lo;
    logic [7:0]  edge_hi;
    logic [7:0]  edge_lo;
    logic [7:0]  irq_en;
    logic [7:0]  sys2;
    logic [7:0]  channel_flag_reg;
    logic        overflow_flag;
    logic [7:0]  comp_out;
    logic [7:0]  next_comp_out;
    logic [7:0]  pin_meta;
    logic [7:0]  pin_sync;
    logic [7:0]  pin_prev;
    logic [7:0]  compare_hit;
    logic [7:0]  cap_evt;
    logic [7:0]  ovr_vec;
    logic [7:0]  tov_vec;
    logic [7:0]  act_any;
    logic [15:0] act_all;
    logic [15:0] edge_all;
    logic        tick;
    logic        clear_on_7;
    logic        ovf_evt;
    logic        wr_en;

    function automatic logic edge_match(input logic [1:0] sel, input logic rise,
                                        input logic fall);
        case (sel)
            timer_ctrl_pkg::EDGE_RISE: edge_match = rise;
            timer_ctrl_pkg::EDGE_FALL: edge_match = fall;
            timer_ctrl_pkg::EDGE_ANY:  edge_match = rise | fall;
            default:                   edge_match = 1'b0;
        endcase
    endfunction

    timer_prescaler u_prescaler (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .select  (sys2[2:0]),
        .tick    (tick)
    );

    assign act_all    = {act_hi, act_lo};
    assign edge_all   = {edge_hi, edge_lo};
    assign clear_on_7 = sys2[timer_ctrl_pkg::SYS2_CLR7];
    assign wr_en      = bus.wr;

    // Pin inputs cross into the bus clock domain through two flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_meta <= timer_ctrl_pkg::RST_REG;
            pin_sync <= timer_ctrl_pkg::RST_REG;
            pin_prev <= timer_ctrl_pkg::RST_REG;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Compare is taken while the counter holds the value, on the tick that moves it on
    always_comb begin
        for (int i = 0; i < timer_ctrl_pkg::NCH; i++) begin
            compare_hit[i] = tick && channel_io_select[i] && (main_counter == compare_value[i]);
            cap_evt[i]     = !channel_io_select[i] && edge_match(edge_all[2*i +: 2],
                             pin_sync[i] & ~pin_prev[i], ~pin_sync[i] & pin_prev[i]);
            act_any[i]     = act_all[2*i+1] | act_all[2*i];
        end
    end
    assign capture_strobe = cap_evt;

    // A clearing compare at the top of the range is not a rollover
    assign ovf_evt = tick && (main_counter == timer_ctrl_pkg::CNT_MAX)
                     && !(clear_on_7 && compare_hit[7]);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            main_counter <= timer_ctrl_pkg::RST_CNT;
        end else if (tick) begin
            if (clear_on_7 && compare_hit[7]) begin
                main_counter <= timer_ctrl_pkg::RST_CNT;
            end else begin
                main_counter <= main_counter + 16'h0001;
            end
        end
    end

    assign ovr_vec = {8{compare_hit[7]}} & ch7_override_mask;
    assign tov_vec = {8{ovf_evt}} & overflow_toggle_enable & channel_io_select;

    // Priority per channel: channel-7 override, then overflow toggle, then compare or force
    always_comb begin
        next_comp_out = comp_out;
        for (int i = 0; i < timer_ctrl_pkg::NCH; i++) begin
            if (ovr_vec[i]) begin
                next_comp_out[i] = ch7_override_data[i];
            end else if (tov_vec[i]) begin
                next_comp_out[i] = ~comp_out[i];
            end else if (channel_io_select[i] && (compare_hit[i] || force_compare[i])) begin
                case (act_all[2*i +: 2])
                    timer_ctrl_pkg::ACT_TOGGLE: next_comp_out[i] = ~comp_out[i];
                    timer_ctrl_pkg::ACT_CLEAR:  next_comp_out[i] = 1'b0;
                    timer_ctrl_pkg::ACT_SET:    next_comp_out[i] = 1'b1;
                    default:                    next_comp_out[i] = comp_out[i];
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            comp_out <= timer_ctrl_pkg::RST_REG;
        end else begin
            comp_out <= next_comp_out;
        end
    end

    // Mask bits of channels 0..6 also claim the pin; software keeps them clear for OM/OL use
    assign pin_drive = '{out: comp_out,
                         oe:  channel_io_select
                              & (act_any | (ch7_override_mask & timer_ctrl_pkg::CH_MASK_0_6))};

    // Control registers, writable at any time
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            overflow_toggle_enable <= timer_ctrl_pkg::RST_REG;
            act_hi                 <= timer_ctrl_pkg::RST_REG;
            act_lo                 <= timer_ctrl_pkg::RST_REG;
        end else if (wr_en) begin
            case (bus.addr)
                timer_ctrl_pkg::OFS_TOGGLE: overflow_toggle_enable <= bus.wdata;
                timer_ctrl_pkg::OFS_ACT_HI: act_hi <= bus.wdata;
                timer_ctrl_pkg::OFS_ACT_LO: act_lo <= bus.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            edge_hi <= timer_ctrl_pkg::RST_REG;
            edge_lo <= timer_ctrl_pkg::RST_REG;
            irq_en  <= timer_ctrl_pkg::RST_REG;
            sys2    <= timer_ctrl_pkg::RST_REG;
        end else if (wr_en) begin
            case (bus.addr)
                timer_ctrl_pkg::OFS_EDGE_HI: edge_hi <= bus.wdata;
                timer_ctrl_pkg::OFS_EDGE_LO: edge_lo <= bus.wdata;
                timer_ctrl_pkg::OFS_IRQ_EN:  irq_en  <= bus.wdata;
                timer_ctrl_pkg::OFS_SYS2:    sys2    <= bus.wdata & timer_ctrl_pkg::SYS2_MASK;
                default: ;
            endcase
        end
    end

    // Write-one-to-clear flags; a hardware set in the same cycle wins over the clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            channel_flag_reg <= timer_ctrl_pkg::RST_REG;
            overflow_flag    <= 1'b0;
        end else begin
            channel_flag_reg <= (channel_flag_reg
                                 & ~({8{wr_en && bus.addr == timer_ctrl_pkg::OFS_CH_FLAG}}
                                     & bus.wdata))
                                | compare_hit | cap_evt;
            overflow_flag    <= (overflow_flag
                                 & ~(wr_en && bus.addr == timer_ctrl_pkg::OFS_OVF_FLAG
                                     && bus.wdata[timer_ctrl_pkg::OVF_FLAG_BIT]))
                                | ovf_evt;
        end
    end

    assign irq_channel  = |(channel_flag_reg & irq_en);
    assign irq_overflow = overflow_flag && sys2[timer_ctrl_pkg::SYS2_OVF_IE];

    // Read data stand only in the cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !bus.rd) begin
            rd_data <= timer_ctrl_pkg::RST_REG;
        end else begin
            case (bus.addr)
                timer_ctrl_pkg::OFS_TOGGLE:   rd_data <= overflow_toggle_enable;
                timer_ctrl_pkg::OFS_ACT_HI:   rd_data <= act_hi;
                timer_ctrl_pkg::OFS_ACT_LO:   rd_data <= act_lo;
                timer_ctrl_pkg::OFS_EDGE_HI:  rd_data <= edge_hi;
                timer_ctrl_pkg::OFS_EDGE_LO:  rd_data <= edge_lo;
                timer_ctrl_pkg::OFS_IRQ_EN:   rd_data <= irq_en;
                timer_ctrl_pkg::OFS_SYS2:     rd_data <= sys2;
                timer_ctrl_pkg::OFS_CH_FLAG:  rd_data <= channel_flag_reg;
                timer_ctrl_pkg::OFS_OVF_FLAG: rd_data <= {overflow_flag, 7'h00};
                timer_ctrl_pkg::OFS_CNT_HI:   rd_data <= main_counter[15:8];
                timer_ctrl_pkg::OFS_CNT_LO:   rd_data <= main_counter[7:0];
                default:                      rd_data <= timer_ctrl_pkg::RST_REG;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_tov;
        ovf_evt |=> ((comp_out ^ $past(comp_out)) & $past(tov_vec & ~ovr_vec))
                    == $past(tov_vec & ~ovr_vec);
    endproperty
    a_tov: assert property (p_tov) else $error("overflow toggle missed");

    property p_ic_quiet;
        ##1 ((comp_out ^ $past(comp_out)) & ~$past(channel_io_select | ch7_override_mask)) == 8'h00;
    endproperty
    a_ic_quiet: assert property (p_ic_quiet) else $error("capture channel pin moved");

    property p_override;
        compare_hit[7] |=> (comp_out & $past(ch7_override_mask))
                           == ($past(ch7_override_data) & $past(ch7_override_mask));
    endproperty
    a_override: assert property (p_override) else $error("override data not applied");

    property p_act_clear;
        (compare_hit[1] && act_all[3:2] == 2'h2 && !ovr_vec[1] && !tov_vec[1]) |=> !comp_out[1];
    endproperty
    a_act_clear: assert property (p_act_clear) else $error("clear action failed");

    property p_oe;
        (channel_io_select[1] && act_all[3:2] != 2'h0) |-> pin_drive.oe[1];
    endproperty
    a_oe: assert property (p_oe) else $error("pin not driven");

    property p_rise;
        (!channel_io_select[4] && edge_all[9:8] == 2'h1 && pin_sync[4] && !pin_prev[4])
        |-> capture_strobe[4] ##1 channel_flag_reg[4];
    endproperty
    a_rise: assert property (p_rise) else $error("rising capture lost");

    property p_irq;
        irq_channel == ((channel_flag_reg & irq_en) != 8'h00);
    endproperty
    a_irq: assert property (p_irq) else $error("channel request mismatch");

    property p_ovf_irq;
        (overflow_flag && !sys2[7]) |-> !irq_overflow;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request not inhibited");

    property p_modclr;
        (clear_on_7 && compare_hit[7]) |=> main_counter == 16'h0000;
    endproperty
    a_modclr: assert property (p_modclr) else $error("counter not cleared");

    property p_free;
        (!clear_on_7 && tick) |=> main_counter == $past(main_counter) + 16'h0001;
    endproperty
    a_free: assert property (p_free) else $error("counter not free running");

    property p_tof;
        (tick && main_counter == 16'hFFFF) |=>
            (overflow_flag == !($past(clear_on_7) && $past(compare_hit[7])) || $past(overflow_flag));
    endproperty
    a_tof: assert property (p_tof) else $error("overflow flag wrong on rollover");

    c_capture:  cover property (capture_strobe[4] ##1 irq_channel);
    c_override: cover property (compare_hit[7] && ovf_evt && (ch7_override_mask != 8'h00));
    c_modulus:  cover property (clear_on_7 && compare_hit[7] && main_counter != 16'h0000);
    c_ovf_irq:  cover property ($rose(irq_overflow));
endmodule // timer_channel_action_control
`default_nettype wire

//--- timer_ctrl_pkg.sv
// Shared constants and carrier types for the timer channel action control block
package timer_ctrl_pkg;
    localparam int            NCH          = 8;
    localparam int            CNT_W        = 16;
    localparam int            PRE_W        = 7;
    localparam int            SEL_W        = 3;
    // Register offsets on the byte register port
    localparam logic [3:0]    OFS_TOGGLE   = 4'h0;
    localparam logic [3:0]    OFS_ACT_HI   = 4'h1;
    localparam logic [3:0]    OFS_ACT_LO   = 4'h2;
    localparam logic [3:0]    OFS_EDGE_HI  = 4'h3;
    localparam logic [3:0]    OFS_EDGE_LO  = 4'h4;
    localparam logic [3:0]    OFS_IRQ_EN   = 4'h5;
    localparam logic [3:0]    OFS_SYS2     = 4'h6;
    localparam logic [3:0]    OFS_CH_FLAG  = 4'h7;
    localparam logic [3:0]    OFS_OVF_FLAG = 4'h8;
    localparam logic [3:0]    OFS_CNT_HI   = 4'h9;
    localparam logic [3:0]    OFS_CNT_LO   = 4'hA;
    // Field positions in system_ctrl_two and the overflow flag register
    localparam int            SYS2_OVF_IE  = 7;
    localparam int            SYS2_CLR7    = 3;
    localparam int            OVF_FLAG_BIT = 7;
    localparam logic [7:0]    SYS2_MASK    = 8'h8F;
    localparam logic [7:0]    CH_MASK_0_6  = 8'h7F;
    // Reset values and counter and prescaler limits
    localparam logic [7:0]    RST_REG      = 8'h00;
    localparam logic [15:0]   RST_CNT      = 16'h0000;
    localparam logic [15:0]   CNT_MAX      = 16'hFFFF;
    localparam logic [PRE_W-1:0] PRE_ZERO  = 7'h00;
    localparam logic [PRE_W-1:0] PRE_FULL  = 7'h7F;
    // Compare pin action and capture edge encodings
    localparam logic [1:0]    ACT_OFF      = 2'h0;
    localparam logic [1:0]    ACT_TOGGLE   = 2'h1;
    localparam logic [1:0]    ACT_CLEAR    = 2'h2;
    localparam logic [1:0]    ACT_SET      = 2'h3;
    localparam logic [1:0]    EDGE_OFF     = 2'h0;
    localparam logic [1:0]    EDGE_RISE    = 2'h1;
    localparam logic [1:0]    EDGE_FALL    = 2'h2;
    localparam logic [1:0]    EDGE_ANY     = 2'h3;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_s;
endpackage

//--- timer_prescaler.sv
// Bus clock prescaler producing the counter tick enable
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler (
    input  wire logic                           clk_sys,
    input  wire logic                           sys_rst,
    input  wire logic [timer_ctrl_pkg::SEL_W-1:0] select,
    output logic                                tick
);
    logic [timer_ctrl_pkg::PRE_W-1:0] stage_cnt;
    logic [timer_ctrl_pkg::SEL_W-1:0] active_sel;

    function automatic logic [timer_ctrl_pkg::PRE_W-1:0] low_mask(
        input logic [timer_ctrl_pkg::SEL_W-1:0] s);
        low_mask = ~(timer_ctrl_pkg::PRE_FULL << s);
    endfunction

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage_cnt <= timer_ctrl_pkg::PRE_ZERO;
        end else begin
            stage_cnt <= stage_cnt + 7'h01;
        end
    end

    // A new ratio is adopted only with every stage at zero, so no short period appears
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            active_sel <= 3'h0;
        end else if (stage_cnt == timer_ctrl_pkg::PRE_ZERO) begin
            active_sel <= select;
        end
    end

    // Tick once every 2**active_sel bus cycles
    assign tick = (stage_cnt & low_mask(active_sel)) == low_mask(active_sel);

    property p_div8;
        @(posedge clk_sys) disable iff (sys_rst)
        // The window after the tick at the top stage spans a possible ratio change
        (tick && active_sel == 3'h3 && $stable(active_sel)
            && stage_cnt != timer_ctrl_pkg::PRE_FULL) |=> !tick [*7] ##1 tick;
    endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 spacing wrong");

    property p_sel_sync;
        @(posedge clk_sys) disable iff (sys_rst)
        $changed(active_sel) |-> $past(stage_cnt) == 7'h00;
    endproperty
    a_sel_sync: assert property (p_sel_sync) else $error("ratio changed off stage zero");
endmodule // timer_prescaler
`default_nettype wire

//--- timer_pin_partner.sv
// Model of the external circuitry on the eight timer pins
`timescale 1ns/10ps
`default_nettype none
module timer_pin_partner (
    input  wire timer_ctrl_pkg::pin_drive_s drive,
    output logic [7:0]                      pin_in
);
    logic [7:0] ext_level = 8'h00;
    // The timer owns the wire where it drives; the outside source elsewhere
    assign pin_in = (drive.oe & drive.out) | (~drive.oe & ext_level);
    task automatic set_level(input int ch, input logic v);
        ext_level[ch] <= v;
    endtask
endmodule // timer_pin_partner
`default_nettype wire

//--- timer_channel_action_control_bench.sv
// Self-checking bench for the timer channel action control block
`timescale 1ns/10ps
`default_nettype none
module timer_channel_action_control_bench;
    logic                       clk_sys = 1'b0;
    logic                       sys_rst = 1'b1;
    timer_ctrl_pkg::bus_req_s   bus = '0;
    logic [7:0]                 rd_data;
    logic [7:0][15:0]           compare_value = {16'h0010, {7{16'h1234}}};
    logic [7:0]                 io_sel = 8'h87;
    logic [7:0]                 force_compare = 8'h00;
    logic [7:0]                 ovr_mask = 8'h00; // Bit 7 never set
    logic [7:0]                 ovr_data = 8'h00;
    logic [7:0]                 pin_in;
    timer_ctrl_pkg::pin_drive_s pin_drive;
    logic [7:0]                 capture_strobe;
    logic [15:0]                main_counter;
    logic                       irq_channel;
    logic                       irq_overflow;
    int                         n_mismatch = 0;
    int                         n_checks = 0;

    always #25 clk_sys = ~clk_sys;

    timer_channel_action_control dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus),
        .rd_data(rd_data), .compare_value(compare_value), .channel_io_select(io_sel),
        .ch7_override_mask(ovr_mask), .ch7_override_data(ovr_data),
        .force_compare(force_compare), .pin_in(pin_in), .pin_drive(pin_drive),
        .capture_strobe(capture_strobe), .main_counter(main_counter),
        .irq_channel(irq_channel), .irq_overflow(irq_overflow));
    timer_pin_partner partner (.drive(pin_drive), .pin_in(pin_in));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the read edge, so sample them there
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        chk({8'h00, rd_data}, {8'h00, exp}, what);
    endtask
    task automatic park;
        for (int k = 0; k < 1000 && main_counter !== compare_value[7]; k++) @(negedge clk_sys);
        @(posedge clk_sys);
        compare_value[7] <= 16'h0000;
    endtask

    task automatic t_clear;
        logic [15:0] mx;
        wr(timer_ctrl_pkg::OFS_SYS2, 8'h08);
        park;
        repeat (2) @(posedge clk_sys);
        for (int k = 0; k < 20; k++) begin
            @(negedge clk_sys);
            chk(main_counter, 16'h0000, "parked counter");
        end
        @(posedge clk_sys);
        compare_value[7] <= 16'h0009;
        compare_value[0] <= 16'h0005;
        wr(timer_ctrl_pkg::OFS_ACT_LO, 8'h03);
        mx = 16'h0000;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk_sys);
            if (main_counter > mx) mx = main_counter;
        end
        chk(mx, 16'h0009, "modulus top");
        chk({15'h0, pin_drive.out[0]}, 16'h0001, "set on compare");
        rdchk(timer_ctrl_pkg::OFS_CH_FLAG, 8'h81, "compare flags");
        park;
    endtask

    task automatic t_regs;
        for (int a = 0; a < 6; a++) begin
            wr(a[3:0], 8'hA5 ^ a[7:0]);
            rdchk(a[3:0], 8'hA5 ^ a[7:0], "register readback");
            wr(a[3:0], 8'h00);
        end
        wr(timer_ctrl_pkg::OFS_ACT_LO, 8'h03);
        wr(timer_ctrl_pkg::OFS_SYS2, 8'hF8);
        rdchk(timer_ctrl_pkg::OFS_SYS2, 8'h88, "control two readback");
        wr(4'hB, 8'hFF);
        rdchk(4'hB, 8'h00, "unmapped read");
        wr(timer_ctrl_pkg::OFS_SYS2, 8'h08);
    endtask

    task automatic t_prescale;
        logic [15:0] last;
        int n;
        @(posedge clk_sys);
        compare_value[7] <= 16'h0200;
        // A new divider waits for the stage counter to wrap, so settle first
        for (int s = 0; s < 7; s += 3) begin
            wr(timer_ctrl_pkg::OFS_SYS2, {5'b00001, s[2:0]});
            repeat (130) @(posedge clk_sys);
            @(negedge clk_sys);
            last = main_counter;
            for (int k = 0; k < 300 && main_counter === last; k++) @(negedge clk_sys);
            last = main_counter;
            n = 0;
            for (int k = 0; k < 300 && main_counter === last; k++) begin
                @(negedge clk_sys);
                n++;
            end
            chk(n[15:0], 16'h0001 << s, "tick spacing");
        end
        wr(timer_ctrl_pkg::OFS_SYS2, 8'h08);
        repeat (130) @(posedge clk_sys);
        park;
    endtask

    task automatic t_actions;
        logic [1:0] code [5] = '{2'h3, 2'h0, 2'h1, 2'h1, 2'h2};
        logic       expv [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            wr(timer_ctrl_pkg::OFS_ACT_LO, {4'h0, code[i], 2'h3});
            #1;
            chk({15'h0, pin_drive.oe[1]}, {15'h0, code[i] != 2'h0}, "pin enable");
            @(posedge clk_sys);
            force_compare <= 8'h02;
            @(posedge clk_sys);
            force_compare <= 8'h00;
            #1;
            chk({15'h0, pin_drive.out[1]}, {15'h0, expv[i]}, "pin action");
        end
    endtask

    task automatic t_capture;
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(timer_ctrl_pkg::OFS_EDGE_HI, {6'h00, c[1:0]});
            n = 0;
            for (int k = 0; k < 16; k++) begin
                @(posedge clk_sys);
                if (k == 0) partner.set_level(4, 1'b1);
                if (k == 8) partner.set_level(4, 1'b0);
                @(negedge clk_sys);
                if (capture_strobe[4] === 1'b1) n++;
            end
            chk(n[15:0], (c == 3) ? 16'h0002 : {15'h0, c != 0}, "capture count");
        end
        rdchk(timer_ctrl_pkg::OFS_CH_FLAG, 8'h91, "capture flag");
        chk({15'h0, irq_channel}, 16'h0000, "request masked");
        wr(timer_ctrl_pkg::OFS_IRQ_EN, 8'h10);
        #1;
        chk({15'h0, irq_channel}, 16'h0001, "request enabled");
        wr(timer_ctrl_pkg::OFS_CH_FLAG, 8'h10);
        #1;
        chk({15'h0, irq_channel}, 16'h0000, "request cleared");
    endtask

    // Counter parked with channel 7 hitting every tick; channel 1 is set to clear on compare
    task automatic t_override;
        @(posedge clk_sys);
        ovr_mask      <= 8'h02;
        ovr_data      <= 8'h02;
        force_compare <= 8'h02;
        @(posedge clk_sys);
        force_compare <= 8'h00;
        #1;
        chk({15'h0, pin_drive.out[1]}, 16'h0001, "override beats clear");
        @(posedge clk_sys);
        ovr_mask <= 8'h00;
        @(posedge clk_sys);
        force_compare <= 8'h02;
        @(posedge clk_sys);
        force_compare <= 8'h00;
        #1;
        chk({15'h0, pin_drive.out[1]}, 16'h0000, "clear after override");
    endtask

    task automatic t_overflow;
        wr(timer_ctrl_pkg::OFS_TOGGLE, 8'h0C);
        wr(timer_ctrl_pkg::OFS_SYS2, 8'h80);
        for (int k = 0; k < 70000 && main_counter !== 16'hFFFF; k++) @(negedge clk_sys);
        chk({15'h0, irq_overflow}, 16'h0000, "no overflow yet");
        chk({15'h0, pin_drive.out[2]}, 16'h0000, "toggle pin before");
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(main_counter, 16'h0001, "free run wrap");
        chk({15'h0, pin_drive.out[2]}, 16'h0001, "toggle pin after");
        chk({14'h0, pin_drive.oe[3], pin_drive.out[3]}, 16'h0000, "capture pin");
        chk({15'h0, irq_overflow}, 16'h0001, "overflow request");
        rdchk(timer_ctrl_pkg::OFS_OVF_FLAG, 8'h80, "overflow flag");
        wr(timer_ctrl_pkg::OFS_SYS2, 8'h00);
        #1;
        chk({15'h0, irq_overflow}, 16'h0000, "overflow inhibited");
        rdchk(timer_ctrl_pkg::OFS_OVF_FLAG, 8'h80, "flag kept");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk_sys);
        n_mismatch++;
        $display("wrong value at %0t: watchdog expired", $time);
        final_report;
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_clear;
        t_regs;
        t_prescale;
        t_actions;
        t_capture;
        t_override;
        t_overflow;
        final_report;
    end
endmodule // timer_channel_action_control_bench
`default_nettype wire
